/* File: mcf_pkg.sv */
// Purpose: Constants for the monitor configuration and fan divisor registers.
// Assumes: 8-bit register port reached by offset, one clock.
// Notes:   Offsets, bit positions and reset values for mcf_regs live here; the checker and testbench repeat them as literals.
package mcf_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] MCF_OFS_MAIN_CFG = 8'h00;  // Main configuration
  localparam logic [7:0] MCF_OFS_PIN_SEL  = 8'h01;  // Pin function select
  localparam logic [7:0] MCF_OFS_PRESCALE = 8'h02;  // Tach prescaler, fans 0..3
  localparam logic [7:0] MCF_OFS_ANA_FAN  = 8'h04;  // Analog fan value (outside)
  localparam logic [7:0] MCF_OFS_PWM_FAN  = 8'h05;  // Pulse-width fan value (outside)

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MCF_RST_MAIN_CFG = 8'h00;
  localparam logic [7:0] MCF_RST_PIN_SEL  = 8'h00;
  localparam logic [7:0] MCF_RST_PRESCALE = 8'h55;
  localparam logic [7:0] MCF_RST_FAN_VAL  = 8'hFF;  // Fan value registers

  // ------------------------------------------------------------
  // Main configuration bit positions
  // ------------------------------------------------------------
  localparam int MCF_B_MONITOR   = 0;
  localparam int MCF_B_INT_EN    = 1;
  localparam int MCF_B_INT_CLR   = 2;
  localparam int MCF_B_AUX_SEL   = 3;
  localparam int MCF_B_ALARM_EN  = 4;
  localparam int MCF_B_ANA_AUTO  = 5;
  localparam int MCF_B_PWM_AUTO  = 6;
  localparam int MCF_B_SOFT_RST  = 7;

  // ------------------------------------------------------------
  // Prescaler field layout and full scale
  // ------------------------------------------------------------
  localparam int         MCF_PRE_W     = 2;      // Bits per fan field
  localparam int         MCF_NUM_FANS  = 4;      // Fields in the register
  localparam logic [7:0] MCF_FULL_SCALE = 8'hFF; // Forced fan drive

endpackage : mcf_pkg

/* File: mcf_tach_div.sv */
// Purpose: Divides the tach oscillator tick by 1, 2, 4 or 8 per code.
// Assumes: osc_tick_in is a one-cycle pulse at the oscillator rate.
// Notes:   Code 00..11 gives 22.5, 11.25, 5.62, 2.81 kHz count clocks.
module mcf_tach_div (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic [1:0] code_in,
  input  wire logic       osc_tick_in,
  // Divided tick
  output logic            count_tick_out
);

  logic [2:0] cnt_r;    // Oscillator tick counter
  logic [2:0] cnt_nxt;
  logic       tick_r;   // Registered divided tick
  logic       tick_nxt;
  logic [2:0] last_c;   // Terminal count for this code

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  // Terminal count is 2^code - 1; a code change mid-count just retimes once
  always_comb begin
    last_c   = 3'((4'h1 << code_in) - 4'h1);
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (osc_tick_in) begin
      if (cnt_r >= last_c) begin
        cnt_nxt  = 3'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r  <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign count_tick_out = tick_r;

endmodule : mcf_tach_div

/* File: mcf_regs.sv */
// Purpose: Main configuration, pin function select and fan 0..3 prescaler
//          registers, plus the control they steer.
// Assumes: Simple synchronous register port; one clock at 100 MHz.
// Notes:   Measurement, limits and fan value storage lie outside this block.

module mcf_regs #(
  parameter int NUM_FANS = 4  // Prescaler fields in this register
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Events from, and control outputs to, the measurement engine
  input  wire logic       chan_limit_evt_in,
  input  wire logic       gp_int_level_in,
  input  wire logic       thermal_alarm_pin_limit_in,
  output logic            monitor_run_out,
  output logic            aux_inputs_sel_out,
  output logic            soft_reset_out,
  // Interrupt pin
  output logic            int_pin_out,
  // Thermal alarm pin, open drain
  input  wire logic       thermal_alarm_pin_in,
  output logic            thermal_alarm_pin_out,
  output logic            thermal_alarm_pin_oe_n_out,
  // Fan output values
  input  wire logic [7:0] ana_fan_reg_in,
  input  wire logic [7:0] pwm_fan_reg_in,
  input  wire logic [7:0] ana_auto_in,
  input  wire logic [7:0] pwm_auto_in,
  output logic      [7:0] ana_fan_out,
  output logic      [7:0] pwm_fan_out,
  output logic      [3:0] ana_min_speed_out,
  output logic      [3:0] pwm_min_speed_out,
  // Pin function and tach clocks
  output logic      [7:0] gp_pin_mode_out,
  input  wire logic       osc_tick_in,
  output logic [NUM_FANS-1:0] fan_count_tick_out
);

  // Only four 2-bit fields fit the 8-bit prescaler register
  if (NUM_FANS != mcf_pkg::MCF_NUM_FANS) begin : g_bad_fans
    $error("NUM_FANS must match the prescaler register layout");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] main_configuration_r;       // Offset 00h
  logic [7:0] main_configuration_nxt;
  logic [7:0] pin_function_select_r;      // Offset 01h
  logic [7:0] pin_function_select_nxt;
  logic [7:0] tach_prescaler_low_fans_r;  // Offset 02h
  logic [7:0] tach_prescaler_low_fans_nxt;
  logic       chan_int_r;                 // Latched channel interrupt
  logic       chan_int_nxt;
  logic [7:0] rdata_r;                    // Registered read data
  logic [7:0] rdata_nxt;
  logic       soft_rst_c;                 // Soft reset in effect
  logic       alarm_in_low_c;             // Pin pulled low by anyone

  // Write strobe for one offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    return reg_wr_in && (reg_addr_in == ofs);
  endfunction : wr_hit

  // ------------------------------------------------------------
  // Register next values
  // ------------------------------------------------------------
  // Soft reset holds the other registers at power-on values while set;
  // its own bit stays writable so software can release it.
  always_comb begin
    soft_rst_c                  = main_configuration_r[mcf_pkg::MCF_B_SOFT_RST];
    main_configuration_nxt      = main_configuration_r;
    pin_function_select_nxt     = pin_function_select_r;
    tach_prescaler_low_fans_nxt = tach_prescaler_low_fans_r;
    if (wr_hit(mcf_pkg::MCF_OFS_MAIN_CFG)) begin
      main_configuration_nxt = reg_wdata_in;
    end
    if (wr_hit(mcf_pkg::MCF_OFS_PIN_SEL)) begin
      pin_function_select_nxt = reg_wdata_in;
    end
    if (wr_hit(mcf_pkg::MCF_OFS_PRESCALE)) begin
      tach_prescaler_low_fans_nxt = reg_wdata_in;
    end
    if (soft_rst_c) begin
      main_configuration_nxt = mcf_pkg::MCF_RST_MAIN_CFG;
      main_configuration_nxt[mcf_pkg::MCF_B_SOFT_RST] =
        wr_hit(mcf_pkg::MCF_OFS_MAIN_CFG) ? reg_wdata_in[mcf_pkg::MCF_B_SOFT_RST] : 1'b1;
      pin_function_select_nxt     = mcf_pkg::MCF_RST_PIN_SEL;
      tach_prescaler_low_fans_nxt = mcf_pkg::MCF_RST_PRESCALE;
    end
  end

  // ------------------------------------------------------------
  // Channel interrupt latch
  // ------------------------------------------------------------
  // Clear is a level; a new event in a clear cycle still sets the latch,
  // so an out-of-limit channel re-raises on the next pass.
  always_comb begin
    chan_int_nxt = chan_int_r;
    if (main_configuration_r[mcf_pkg::MCF_B_INT_CLR] || soft_rst_c) begin
      chan_int_nxt = 1'b0;
    end
    if (chan_limit_evt_in && !soft_rst_c) begin
      chan_int_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    unique case (reg_addr_in)
      mcf_pkg::MCF_OFS_MAIN_CFG: rdata_nxt = main_configuration_r;
      mcf_pkg::MCF_OFS_PIN_SEL:  rdata_nxt = pin_function_select_r;
      mcf_pkg::MCF_OFS_PRESCALE: rdata_nxt = tach_prescaler_low_fans_r;
      default:                   rdata_nxt = 8'h00;  // Not held here
    endcase
  end

  // Registers only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      main_configuration_r      <= mcf_pkg::MCF_RST_MAIN_CFG;
      pin_function_select_r     <= mcf_pkg::MCF_RST_PIN_SEL;
      tach_prescaler_low_fans_r <= mcf_pkg::MCF_RST_PRESCALE;
      chan_int_r                <= 1'b0;
      rdata_r                   <= 8'h00;
    end else begin
      main_configuration_r      <= main_configuration_nxt;
      pin_function_select_r     <= pin_function_select_nxt;
      tach_prescaler_low_fans_r <= tach_prescaler_low_fans_nxt;
      chan_int_r                <= chan_int_nxt;
      rdata_r                   <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ------------------------------------------------------------
  // Control outputs
  // ------------------------------------------------------------
  assign monitor_run_out    = main_configuration_r[mcf_pkg::MCF_B_MONITOR];
  assign aux_inputs_sel_out = main_configuration_r[mcf_pkg::MCF_B_AUX_SEL];
  assign soft_reset_out     = soft_rst_c;

  // GP pin interrupts are levels, untouched by the clear bit
  assign int_pin_out = main_configuration_r[mcf_pkg::MCF_B_INT_EN]
                       && (chan_int_r || gp_int_level_in);

  // Open drain: oe low pulls the pin low
  assign thermal_alarm_pin_out      = 1'b0;
  assign thermal_alarm_pin_oe_n_out =
    !(main_configuration_r[mcf_pkg::MCF_B_ALARM_EN] && thermal_alarm_pin_limit_in);

  // External pull-down reads low too; both force full scale
  assign alarm_in_low_c = !thermal_alarm_pin_in;

  // ------------------------------------------------------------
  // Fan output selection
  // ------------------------------------------------------------
  always_comb begin
    ana_fan_out = main_configuration_r[mcf_pkg::MCF_B_ANA_AUTO]
                  ? ana_auto_in : ana_fan_reg_in;
    pwm_fan_out = main_configuration_r[mcf_pkg::MCF_B_PWM_AUTO]
                  ? pwm_auto_in : pwm_fan_reg_in;
    if (alarm_in_low_c) begin
      ana_fan_out = mcf_pkg::MCF_FULL_SCALE;
      pwm_fan_out = mcf_pkg::MCF_FULL_SCALE;
    end
  end

  // Upper nibble is the automatic loop's floor
  assign ana_min_speed_out = ana_fan_reg_in[7:4];
  assign pwm_min_speed_out = pwm_fan_reg_in[7:4];

  // One for GP pin, zero for tach input
  assign gp_pin_mode_out = pin_function_select_r;

  // ------------------------------------------------------------
  // Per-fan tach prescalers
  // ------------------------------------------------------------
  for (genvar f = 0; f < NUM_FANS; f++) begin : g_div
    mcf_tach_div u_div (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .code_in        (tach_prescaler_low_fans_r[f*mcf_pkg::MCF_PRE_W +: mcf_pkg::MCF_PRE_W]),
      .osc_tick_in    (osc_tick_in),
      .count_tick_out (fan_count_tick_out[f])
    );
  end

endmodule : mcf_regs

/* File: mcf_pin_model.sv */
// Purpose: Thermal alarm line with pull-up and an outside party.
// Assumes: Design drives through an active-low output enable.
// Notes:   Outside party may sink the line at any time.
module mcf_pin_model (
  // Design side of the open-drain pin
  input  wire logic pin_drv_in,
  input  wire logic pin_oe_n_in,
  // Outside party sinking the line
  input  wire logic ext_pull_low_in,
  // Resolved line level
  output logic      pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins only when nobody sinks the line
  always_comb begin
    pin_level_out = 1'b1;
    if (!pin_oe_n_in) pin_level_out = pin_drv_in;
    if (ext_pull_low_in) pin_level_out = 1'b0;
  end
endmodule : mcf_pin_model

/* File: mcf_regs_checker.sv */
// Purpose: Port assertions for the configuration register bank.
// Assumes: Bound to mcf_regs; one clock domain.
// Notes:   Register state is inferred from the writes seen.
module mcf_regs_checker #(
  parameter int NUM_FANS = 4  // Prescaler fields
) (
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic [7:0]          reg_addr_in,
  input wire logic                reg_wr_in,
  input wire logic [7:0]          reg_wdata_in,
  input wire logic [7:0]          reg_rdata_out,
  input wire logic                chan_limit_evt_in,
  input wire logic                gp_int_level_in,
  input wire logic                thermal_alarm_pin_limit_in,
  input wire logic                monitor_run_out,
  input wire logic                aux_inputs_sel_out,
  input wire logic                soft_reset_out,
  input wire logic                int_pin_out,
  input wire logic                thermal_alarm_pin_in,
  input wire logic                thermal_alarm_pin_out,
  input wire logic                thermal_alarm_pin_oe_n_out,
  input wire logic [7:0]          ana_fan_reg_in,
  input wire logic [7:0]          pwm_fan_reg_in,
  input wire logic [7:0]          ana_fan_out,
  input wire logic [7:0]          pwm_fan_out,
  input wire logic [3:0]          ana_min_speed_out,
  input wire logic [3:0]          pwm_min_speed_out,
  input wire logic [7:0]          gp_pin_mode_out,
  input wire logic                osc_tick_in,
  input wire logic [NUM_FANS-1:0] fan_count_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Main config write that is not a soft reset
  sequence s_cfg_wr;
    reg_wr_in && reg_addr_in == 8'h00 && !reg_wdata_in[7] && !soft_reset_out;
  endsequence
  // Nothing can re-raise or rewrite meanwhile
  sequence s_quiet;
    !chan_limit_evt_in && !gp_int_level_in && !reg_wr_in;
  endsequence
  a_cfg_bits: assert property (
    s_cfg_wr |=> monitor_run_out == $past(reg_wdata_in[0]) && aux_inputs_sel_out == $past(reg_wdata_in[3]))
    else $error("config bits not taken");
  a_int_gate: assert property (
    reg_wr_in && reg_addr_in == 8'h00 && !reg_wdata_in[1] |=> !int_pin_out) else $error("int not gated");
  a_int_clear: assert property (
    s_cfg_wr ##0 reg_wdata_in[2] ##1 s_quiet [*3] |-> !int_pin_out) else $error("int not cleared");
  a_alarm_on: assert property (
    s_cfg_wr ##0 reg_wdata_in[4] ##1 thermal_alarm_pin_limit_in |-> !thermal_alarm_pin_oe_n_out) else $error("alarm not driven");
  a_alarm_cause: assert property (
    !thermal_alarm_pin_oe_n_out |-> thermal_alarm_pin_limit_in && !thermal_alarm_pin_out) else $error("alarm without cause");
  a_fan_force: assert property (
    !thermal_alarm_pin_in |-> ana_fan_out == 8'hFF && pwm_fan_out == 8'hFF) else $error("fans not full scale");
  a_min_speed: assert property (
    ana_min_speed_out == ana_fan_reg_in[7:4] && pwm_min_speed_out == pwm_fan_reg_in[7:4]) else $error("min speed");
  a_pin_mode: assert property (
    reg_wr_in && reg_addr_in == 8'h01 && !soft_reset_out |=> gp_pin_mode_out == $past(reg_wdata_in))
    else $error("pin mode not taken");
  a_soft_hold: assert property (
    soft_reset_out && $past(soft_reset_out) |-> !monitor_run_out && gp_pin_mode_out == 8'h00)
    else $error("soft reset not held");
  a_tick_cause: assert property (
    |fan_count_tick_out |-> $past(osc_tick_in)) else $error("tick without osc");
  a_unmapped_rd: assert property (
    reg_addr_in > 8'h02 |=> reg_rdata_out == 8'h00) else $error("unmapped read");
endmodule : mcf_regs_checker

/* File: testbench.sv */
// Purpose: Directed register and pin tests of mcf_regs.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Register reads are one cycle after the address.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NUM_FANS = 4;  // Design needs four fields
  logic       clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic       chan_limit_evt_in = 1'b0, gp_int_level_in = 1'b0, thermal_alarm_pin_limit_in = 1'b0;
  logic       osc_tick_in = 1'b0, ext_low = 1'b0, cnt_en = 1'b0;
  logic       monitor_run_out, aux_inputs_sel_out, soft_reset_out, int_pin_out;
  logic       thermal_alarm_pin_in, thermal_alarm_pin_out, thermal_alarm_pin_oe_n_out;
  logic [7:0] ana_fan_reg_in = 8'h3C, pwm_fan_reg_in = 8'hC3, ana_auto_in = 8'h11, pwm_auto_in = 8'h22;
  logic [7:0] ana_fan_out, pwm_fan_out, gp_pin_mode_out;
  logic [3:0] ana_min_speed_out, pwm_min_speed_out, fan_count_tick_out;
  logic [7:0] cnt [4] = '{default: 8'h00};  // Divided ticks per fan
  int         num_errors = 0, n_tests = 0, cycles = 0;
  mcf_regs #(.NUM_FANS(NUM_FANS)) u_mcf_regs (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .chan_limit_evt_in, .gp_int_level_in, .thermal_alarm_pin_limit_in, .monitor_run_out, .aux_inputs_sel_out,
    .soft_reset_out, .int_pin_out, .thermal_alarm_pin_in, .thermal_alarm_pin_out, .thermal_alarm_pin_oe_n_out,
    .ana_fan_reg_in, .pwm_fan_reg_in, .ana_auto_in, .pwm_auto_in, .ana_fan_out, .pwm_fan_out, .ana_min_speed_out,
    .pwm_min_speed_out, .gp_pin_mode_out, .osc_tick_in, .fan_count_tick_out);
  mcf_pin_model u_mcf_pin_model (.pin_drv_in(thermal_alarm_pin_out), .pin_oe_n_in(thermal_alarm_pin_oe_n_out),
    .ext_pull_low_in(ext_low), .pin_level_out(thermal_alarm_pin_in));
  initial forever #5 clk_in = ~clk_in;
  // Tick counting and hang guard; limit is about twenty times the test length
  always @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) if (cnt_en && fan_count_tick_out[i]) cnt[i] <= cnt[i] + 8'h01;
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    reg_addr_in = a;
    @(negedge clk_in);
    chk(reg_rdata_out, e);
  endtask : rd
  // Single-cycle channel event
  task automatic evt();
    @(negedge clk_in) chan_limit_evt_in = 1'b1;
    @(negedge clk_in) chan_limit_evt_in = 1'b0;
  endtask : evt
  initial begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) rst_n_in = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h55);
    rd(8'h03, 8'h00);
    chk(ana_fan_out, 8'h3C);
    chk(pwm_fan_out, 8'hC3);
    chk({ana_min_speed_out, pwm_min_speed_out}, 8'h3C);
    wr(8'h01, 8'hA5);
    chk(gp_pin_mode_out, 8'hA5);
    wr(8'h00, 8'h69);
    rd(8'h00, 8'h69);
    chk({6'h00, monitor_run_out, aux_inputs_sel_out}, 8'h03);
    chk(ana_fan_out, 8'h11);
    chk(pwm_fan_out, 8'h22);
    // Thermal alarm: own drive, then outside party
    wr(8'h00, 8'h10);
    thermal_alarm_pin_limit_in = 1'b1;
    @(negedge clk_in) chk({7'h00, thermal_alarm_pin_oe_n_out}, 8'h00);
    chk(ana_fan_out, 8'hFF);
    thermal_alarm_pin_limit_in = 1'b0;
    ext_low = 1'b1;
    @(negedge clk_in) chk({pwm_fan_out[6:0], thermal_alarm_pin_oe_n_out}, 8'hFF);
    ext_low = 1'b0;
    @(negedge clk_in) chk(ana_fan_out, 8'h3C);
    // Interrupt raise, clear, level source, re-raise
    wr(8'h00, 8'h03);
    evt();
    chk({7'h00, int_pin_out}, 8'h01);
    wr(8'h00, 8'h07);
    // Three quiet edges so the clear assertion sees its whole sequence
    repeat (3) @(negedge clk_in);
    chk({7'h00, int_pin_out}, 8'h00);
    gp_int_level_in = 1'b1;
    @(negedge clk_in) chk({7'h00, int_pin_out}, 8'h01);
    gp_int_level_in = 1'b0;
    // Event in a clear cycle still sets the latch
    evt();
    chk({7'h00, int_pin_out}, 8'h01);
    wr(8'h00, 8'h03);
    evt();
    chk({7'h00, int_pin_out}, 8'h01);
    wr(8'h00, 8'h01);
    chk({7'h00, int_pin_out}, 8'h00);
    // Prescaler codes 00..11 on fans 0..3
    wr(8'h02, 8'hE4);
    rd(8'h02, 8'hE4);
    for (int k = 0; k < 24; k++) begin
      @(negedge clk_in) osc_tick_in = 1'b1;
      cnt_en = (k >= 8);
      @(negedge clk_in) osc_tick_in = 1'b0;
      @(negedge clk_in);
    end
    @(negedge clk_in) cnt_en = 1'b0;
    for (int i = 0; i < 4; i++) chk(cnt[i], 8'h10 >> i);
    // Soft reset holds the registers, except its own bit, at power-on values
    wr(8'h00, 8'h81);
    wr(8'h01, 8'hFF);
    chk({monitor_run_out, 6'h00, soft_reset_out}, 8'h01);
    rd(8'h00, 8'h80);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h55);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h0F);
    rd(8'h01, 8'h0F);
    complete_run();
  end
endmodule : testbench

bind mcf_regs mcf_regs_checker #(.NUM_FANS(NUM_FANS)) u_mcf_regs_checker (.clk_in, .rst_n_in, .reg_addr_in,
  .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .chan_limit_evt_in, .gp_int_level_in, .thermal_alarm_pin_limit_in,
  .monitor_run_out, .aux_inputs_sel_out, .soft_reset_out, .int_pin_out, .thermal_alarm_pin_in,
  .thermal_alarm_pin_out, .thermal_alarm_pin_oe_n_out, .ana_fan_reg_in, .pwm_fan_reg_in, .ana_fan_out,
  .pwm_fan_out, .ana_min_speed_out, .pwm_min_speed_out, .gp_pin_mode_out, .osc_tick_in, .fan_count_tick_out);
